// [irs_consts.svh]
`ifndef IRS_CONSTS_SVH
`define IRS_CONSTS_SVH
`define IRS_OFS_CTRL        8'h00
`define IRS_OFS_STATUS      8'h04
`define IRS_OFS_IR          8'h08
`define IRS_OFS_MA          8'h0c
`define IRS_CTRL_RUN        0
`define IRS_CTRL_KEY        1
`define IRS_CTRL_RST        1'b0
`define IRS_MA_RST          18'h00000
`define IRS_IR_RST          18'h00000
`define IRS_CLASS_UUO       3'h0
`define IRS_CLASS_FPCH      3'h1
`define IRS_CLASS_2XX       3'h2
`define IRS_CLASS_IOT       3'h7
`define IRS_FPCH_13X        3'h3
`define IRS_FPCH_UNUSED_MAX 6'h19
`define IRS_FSC_CODE        3'h2
`define IRS_GRP_SHIFT       3'h4
`define IRS_GRP_MISC        3'h5
`define IRS_AHB_NONSEQ      2'h2
`define IRS_HRESP_OKAY      1'h0
`endif

// [irs_pkg.sv]
package irs_pkg;
	typedef enum logic [3:0] {
		ST_IDLE  = 4'h0,
		ST_WR    = 4'h1,
		ST_RST   = 4'h2,
		ST_WAIT3 = 4'h3,
		ST_S3    = 4'h4,
		ST_S5    = 4'h5,
		ST_WAIT5 = 4'h6,
		ST_S5A   = 4'h7,
		ST_S6    = 4'h8,
		ST_S6A   = 4'h9,
		ST_WAIT7 = 4'ha,
		ST_S7    = 4'hb
	} irs_state_t;

	typedef logic [7:0] irs_oct_t;

	function automatic irs_oct_t irs_oct_dec(input logic [2:0] code, input logic en);
		irs_oct_dec = en ? irs_oct_t'(8'h01 << code) : 8'h00;
	endfunction : irs_oct_dec
endpackage : irs_pkg

// [irs_decoder.sv]
`timescale 1ns/100ps
`include "irs_consts.svh"
module irs_decoder (
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic [0:17] ir,
	output logic      [7:0]  class_q,
	output logic      [7:0]  io_op_q,
	output logic             fc_unused_q,
	output logic             float_scale_q,
	output logic      [4:0]  char_op_q,
	output logic      [3:0]  float_op_q,
	output logic      [3:0]  float_mode_q,
	output logic             float_round_q,
	output logic             move_group_q,
	output logic      [7:0]  shift_op_q,
	output logic      [7:0]  misc_op_q,
	output logic             no_acc_codes_q,
	output logic             no_index_q
);
	// Primary decoder is always enabled
	wire irs_pkg::irs_oct_t cls = irs_pkg::irs_oct_dec(ir[0:2], 1'b1);
	wire fpch  = cls[`IRS_CLASS_FPCH];
	wire two   = cls[`IRS_CLASS_2XX];
	wire x13   = fpch & (ir[3:5] == `IRS_FPCH_13X);
	wire flt   = fpch & ir[3];
	wire irs_pkg::irs_oct_t c13  = irs_pkg::irs_oct_dec(ir[6:8], x13);
	wire irs_pkg::irs_oct_t grp  = irs_pkg::irs_oct_dec(ir[3:5], two);
	wire irs_pkg::irs_oct_t fop  = irs_pkg::irs_oct_dec({1'b0, ir[4:5]}, flt);
	wire irs_pkg::irs_oct_t fmod = irs_pkg::irs_oct_dec({1'b0, ir[7:8]}, flt);
	wire irs_pkg::irs_oct_t iop  = irs_pkg::irs_oct_dec(ir[10:12], cls[`IRS_CLASS_IOT]);
	wire irs_pkg::irs_oct_t sh   = irs_pkg::irs_oct_dec(ir[6:8], grp[`IRS_GRP_SHIFT]);
	wire irs_pkg::irs_oct_t misc = irs_pkg::irs_oct_dec(ir[6:8], grp[`IRS_GRP_MISC]);

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			class_q        <= 8'h00;
			io_op_q        <= 8'h00;
			fc_unused_q    <= 1'b0;
			float_scale_q  <= 1'b0;
			char_op_q      <= 5'h00;
			float_op_q     <= 4'h0;
			float_mode_q   <= 4'h0;
			float_round_q  <= 1'b0;
			move_group_q   <= 1'b0;
			shift_op_q     <= 8'h00;
			misc_op_q      <= 8'h00;
			no_acc_codes_q <= 1'b0;
			no_index_q     <= 1'b0;
		end else begin
			class_q        <= cls;
			io_op_q        <= iop;
			fc_unused_q    <= fpch & (ir[3:8] <= `IRS_FPCH_UNUSED_MAX);
			float_scale_q  <= c13[`IRS_FSC_CODE];
			char_op_q      <= c13[7:3];
			float_op_q     <= fop[3:0];
			float_mode_q   <= fmod[3:0];
			float_round_q  <= flt & ir[6];
			move_group_q   <= grp[0] | grp[1];
			shift_op_q     <= sh;
			misc_op_q      <= misc;
			no_acc_codes_q <= grp[`IRS_GRP_MISC] & ir[6];
			no_index_q     <= (ir[14:17] == 4'h0);
		end
	end
endmodule : irs_decoder

// [irs_store_ctrl.sv]
// The register offsets and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "irs_consts.svh"
module irs_store_ctrl (
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	// Sequence pulses and levels from execute and memory logic
	input  wire logic        exec_final_pulse,
	input  wire logic        exec_pulse_three,
	input  wire logic        mem_return,
	input  wire logic        fetch_pause_level,
	input  wire logic        store_to_e_write,
	input  wire logic        store_to_e_restart,
	input  wire logic        no_acc_instr,
	input  wire logic        mem_mode_instr,
	input  wire logic        test_no_result,
	input  wire logic        cmp_zero_instr,
	input  wire logic        block_move_done,
	input  wire logic        dbl_shift,
	input  wire logic        float_low_half,
	input  wire logic        fixed_double,
	input  wire logic        protect_violation,
	// Instruction register loading
	input  wire logic [0:17] mem_buffer_reg,
	input  wire logic        main_seq_clear,
	input  wire logic        instr_cycle_load_pulse,
	input  wire logic        addr_cycle_load_pulse,
	input  wire logic        indirect_clear_pulse,
	input  wire logic        char_first_part_done,
	input  wire logic        io_start_pulse,
	// Store chain strobes
	output logic             mb_setup_pulse,
	output logic             mem_write_req,
	output logic             mem_restart_req,
	output logic             store_step_three,
	output logic             mb_from_ar,
	output logic             mb_from_mq,
	output logic             store_final_pulse,
	output logic             new_instr_cycle,
	output logic             key_cycle,
	output logic             halted,
	output logic             protect_fault_channel,
	output logic      [17:0] mem_addr_reg,
	// Instruction register and decode
	output logic      [0:17] instr_reg,
	output logic      [0:6]  io_device_sel,
	output logic      [0:3]  index_sel,
	output logic             indirect_repeat,
	output logic      [7:0]  class_lvl,
	output logic      [7:0]  io_op,
	output logic             fc_unused,
	output logic             float_scale,
	output logic      [4:0]  char_op,
	output logic      [3:0]  float_op,
	output logic      [3:0]  float_mode,
	output logic             float_round,
	output logic             move_group,
	output logic      [7:0]  shift_op,
	output logic      [7:0]  misc_op,
	output logic             no_acc_codes,
	output logic             no_index
);
	irs_pkg::irs_state_t state_q;
	irs_pkg::irs_state_t state_d;
	logic        sf_a_q;
	logic        sf_b_q;
	logic        run_q;
	logic        key_req_q;
	logic        wr_pend_q;
	logic [7:0]  wr_addr_q;
	logic [0:17] ir_q;
	logic [17:0] ma_q;
	logic [31:0] hrdata_q;
	logic        mb_setup_q;
	logic        wreq_q;
	logic        rreq_q;
	logic        st3_q;
	logic        mb_ar_q;
	logic        mb_mq_q;
	logic        st7_q;
	logic        new_instr_q;
	logic        key_cycle_q;
	logic        halted_q;
	logic        cpa_q;

	// Store chain conditions
	wire acc_store_inhibit = no_acc_instr | mem_mode_instr | test_no_result
		| (cmp_zero_instr & (ir_q[9:12] == 4'h0))
		| block_move_done
		| no_acc_codes;
	wire second_acc_store  = dbl_shift | float_low_half | fixed_double;
	wire restart_gate      = store_to_e_restart | fetch_pause_level;
	wire noop_jump         = exec_pulse_three & fc_unused;
	wire final_entry       = state_d == irs_pkg::ST_S7;
	wire go_key            = final_entry & run_q & key_req_q;

	always_comb begin
		state_d = state_q;
		case (state_q)
			irs_pkg::ST_IDLE: begin
				if (noop_jump)
					state_d = irs_pkg::ST_S7;
				else if (exec_final_pulse & store_to_e_write)
					state_d = irs_pkg::ST_WR;
				else if (exec_final_pulse & restart_gate)
					state_d = irs_pkg::ST_RST;
				else if (exec_final_pulse)
					state_d = irs_pkg::ST_S3;
			end
			irs_pkg::ST_WR,
			irs_pkg::ST_RST: state_d = irs_pkg::ST_WAIT3;
			irs_pkg::ST_WAIT3: begin
				if (mem_return & sf_a_q)
					state_d = irs_pkg::ST_S3;
			end
			irs_pkg::ST_S3: begin
				state_d = acc_store_inhibit ? irs_pkg::ST_S7 : irs_pkg::ST_S5;
			end
			irs_pkg::ST_S5: state_d = irs_pkg::ST_WAIT5;
			irs_pkg::ST_WAIT5: begin
				if (mem_return)
					state_d = irs_pkg::ST_S5A;
			end
			irs_pkg::ST_S5A: begin
				state_d = second_acc_store ? irs_pkg::ST_S6 : irs_pkg::ST_S7;
			end
			// The extra state keeps a return still in flight from being taken twice
			irs_pkg::ST_S6: state_d = irs_pkg::ST_S6A;
			irs_pkg::ST_S6A: state_d = irs_pkg::ST_WAIT7;
			irs_pkg::ST_WAIT7: begin
				if (mem_return & sf_b_q)
					state_d = irs_pkg::ST_S7;
			end
			irs_pkg::ST_S7: state_d = irs_pkg::ST_IDLE;
			default: state_d = irs_pkg::ST_IDLE;
		endcase
		if (protect_violation)
			state_d = irs_pkg::ST_S7;
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			state_q <= irs_pkg::ST_IDLE;
		else
			state_q <= state_d;
	end

	// Subroutine flags: sf_a_q sets with the request pulse, sf_b_q one cycle after it (ST_S6A); any memory return or main_seq_clear clears
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sf_a_q <= 1'b0;
			sf_b_q <= 1'b0;
		end else begin
			if (state_q == irs_pkg::ST_WR || state_q == irs_pkg::ST_RST)
				sf_a_q <= 1'b1;
			else if (mem_return || main_seq_clear)
				sf_a_q <= 1'b0;
			if (state_q == irs_pkg::ST_S6A)
				sf_b_q <= 1'b1;
			else if (mem_return || main_seq_clear)
				sf_b_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			ma_q <= `IRS_MA_RST;
		else if (state_d == irs_pkg::ST_S3)
			ma_q <= `IRS_MA_RST;
		else if (state_d == irs_pkg::ST_S5)
			ma_q <= {14'h0000, ir_q[9:12]};
		else if (state_d == irs_pkg::ST_S6)
			ma_q <= ma_q + 18'h00001;
	end

	// Strobes are registered copies of the state being entered, except mb_setup_q and cpa_q, which register input pulses
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			mb_setup_q  <= 1'b0;
			wreq_q      <= 1'b0;
			rreq_q      <= 1'b0;
			st3_q       <= 1'b0;
			mb_ar_q     <= 1'b0;
			mb_mq_q     <= 1'b0;
			st7_q       <= 1'b0;
			new_instr_q <= 1'b0;
			key_cycle_q <= 1'b0;
			cpa_q       <= 1'b0;
		end else begin
			mb_setup_q  <= exec_final_pulse & (state_q == irs_pkg::ST_IDLE);
			wreq_q      <= state_d == irs_pkg::ST_WR || state_d == irs_pkg::ST_S5
				|| state_d == irs_pkg::ST_S6;
			rreq_q      <= state_d == irs_pkg::ST_RST;
			st3_q       <= state_d == irs_pkg::ST_S3;
			mb_ar_q     <= state_d == irs_pkg::ST_S5;
			mb_mq_q     <= state_d == irs_pkg::ST_S6;
			st7_q       <= final_entry;
			new_instr_q <= final_entry & run_q & ~key_req_q;
			key_cycle_q <= go_key;
			cpa_q       <= protect_violation;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			halted_q <= 1'b0;
		else if (final_entry & ~run_q)
			halted_q <= 1'b1;
		else if (main_seq_clear)
			halted_q <= 1'b0;
	end

	// Instruction register, bit 0 is the most significant
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ir_q <= `IRS_IR_RST;
		end else if (main_seq_clear) begin
			ir_q <= `IRS_IR_RST;
		end else begin
			if (instr_cycle_load_pulse)
				ir_q[0:12] <= mem_buffer_reg[0:12];
			else if (io_start_pulse)
				ir_q[12] <= 1'b1;
			if (addr_cycle_load_pulse)
				ir_q[13:17] <= mem_buffer_reg[13:17];
			else if (char_first_part_done)
				ir_q[13:17] <= 5'h00;
			else if (indirect_clear_pulse)
				ir_q[14:17] <= 4'h0;
		end
	end

	irs_decoder u_dec (
		.core_clk       (core_clk),
		.arst_n         (arst_n),
		.ir             (ir_q),
		.class_q        (class_lvl),
		.io_op_q        (io_op),
		.fc_unused_q    (fc_unused),
		.float_scale_q  (float_scale),
		.char_op_q      (char_op),
		.float_op_q     (float_op),
		.float_mode_q   (float_mode),
		.float_round_q  (float_round),
		.move_group_q   (move_group),
		.shift_op_q     (shift_op),
		.misc_op_q      (misc_op),
		.no_acc_codes_q (no_acc_codes),
		.no_index_q     (no_index)
	);

	// AHB-Lite slave, zero wait states, always OKAY
	wire        bus_take = hsel & hready & (htrans == `IRS_AHB_NONSEQ);
	wire        bus_wr   = bus_take & hwrite;
	wire        bus_rd   = bus_take & ~hwrite;
	wire        ctrl_wr  = wr_pend_q & (wr_addr_q == `IRS_OFS_CTRL);
	wire [31:0] status_w = {22'h000000, second_acc_store, acc_store_inhibit, halted_q,
		sf_b_q, sf_a_q, 1'b0, state_q};
	wire [31:0] rd_mux   = (haddr[7:0] == `IRS_OFS_CTRL)   ? {30'h00000000, key_req_q, run_q} :
		(haddr[7:0] == `IRS_OFS_STATUS) ? status_w :
		(haddr[7:0] == `IRS_OFS_IR)     ? {14'h0000, ir_q} :
		(haddr[7:0] == `IRS_OFS_MA)     ? {14'h0000, ma_q} : 32'h00000000;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hrdata_q  <= 32'h00000000;
		end else begin
			wr_pend_q <= bus_wr;
			wr_addr_q <= haddr[7:0];
			hrdata_q  <= bus_rd ? rd_mux : 32'h00000000;
		end
	end

	// Key request: a software set wins over the clear at key-cycle entry
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			run_q     <= `IRS_CTRL_RST;
			key_req_q <= 1'b0;
		end else begin
			if (ctrl_wr)
				run_q <= hwdata[`IRS_CTRL_RUN];
			if (ctrl_wr & hwdata[`IRS_CTRL_KEY])
				key_req_q <= 1'b1;
			else if (go_key)
				key_req_q <= 1'b0;
		end
	end

	assign hreadyout             = 1'b1;
	assign hresp                 = `IRS_HRESP_OKAY;
	assign hrdata                = hrdata_q;
	assign mb_setup_pulse        = mb_setup_q;
	assign mem_write_req         = wreq_q;
	assign mem_restart_req       = rreq_q;
	assign store_step_three      = st3_q;
	assign mb_from_ar            = mb_ar_q;
	assign mb_from_mq            = mb_mq_q;
	assign store_final_pulse     = st7_q;
	assign new_instr_cycle       = new_instr_q;
	assign key_cycle             = key_cycle_q;
	assign halted                = halted_q;
	assign protect_fault_channel = cpa_q;
	assign mem_addr_reg          = ma_q;
	assign instr_reg             = ir_q;
	assign io_device_sel         = ir_q[3:9];
	assign index_sel             = ir_q[14:17];
	assign indirect_repeat       = ir_q[13];
endmodule : irs_store_ctrl

// [irs_store_ctrl_assertions.sv]
`timescale 1ns/100ps
module irs_store_ctrl_assertions (
	input wire logic	core_clk,
	input wire logic	arst_n,
	input wire logic	exec_final_pulse,
	input wire logic	mem_return,
	input wire logic	fetch_pause_level,
	input wire logic	store_to_e_write,
	input wire logic	store_to_e_restart,
	input wire logic	no_acc_instr,
	input wire logic	mem_mode_instr,
	input wire logic	test_no_result,
	input wire logic	cmp_zero_instr,
	input wire logic	block_move_done,
	input wire logic	dbl_shift,
	input wire logic	float_low_half,
	input wire logic	fixed_double,
	input wire logic	protect_violation,
	input wire logic	mb_setup_pulse,
	input wire logic	mem_write_req,
	input wire logic	mem_restart_req,
	input wire logic	store_step_three,
	input wire logic	mb_from_ar,
	input wire logic	mb_from_mq,
	input wire logic	store_final_pulse,
	input wire logic	new_instr_cycle,
	input wire logic	key_cycle,
	input wire logic	halted,
	input wire logic	protect_fault_channel,
	input wire logic [17:0]	mem_addr_reg,
	input wire logic [0:17]	instr_reg,
	input wire logic	no_acc_codes
);
	logic	busy_q;
	logic	wait_e_q;
	logic	wait_ac_q;
	wire	idle = !busy_q && !mb_setup_pulse;
	wire	inh = no_acc_instr || mem_mode_instr || test_no_result || block_move_done
		|| no_acc_codes || (cmp_zero_instr && instr_reg[9:12] == 4'h0);
	wire	sec = dbl_shift || float_low_half || fixed_double;
	// A start pulse during a running chain is refused, so only idle starts count
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			busy_q <= 1'b0;
			wait_e_q <= 1'b0;
			wait_ac_q <= 1'b0;
		end else begin
			busy_q <= mb_setup_pulse || (busy_q && !store_final_pulse);
			wait_e_q <= (mb_setup_pulse && (mem_write_req || mem_restart_req)) || (wait_e_q && !mem_return);
			wait_ac_q <= mb_from_ar || (wait_ac_q && !mem_return);
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	sequence s_start; exec_final_pulse && idle; endsequence
	sequence s_ac_ret; wait_ac_q && mem_return; endsequence
	chk_exec_setup: assert property (s_start |=> mb_setup_pulse)
		else $error("store chain did not start");
	chk_write_req: assert property (s_start ##0 (store_to_e_write && !store_to_e_restart
		&& !fetch_pause_level) |=> mem_write_req) else $error("no write request");
	chk_restart_req: assert property (s_start ##0 (!store_to_e_write && (store_to_e_restart
		|| fetch_pause_level)) |=> mem_restart_req && !mem_write_req) else $error("no restart");
	chk_skip_e: assert property (s_start ##0 !(store_to_e_write || store_to_e_restart
		|| fetch_pause_level) |=> store_step_three && !mem_write_req) else $error("no skip");
	chk_e_return: assert property (wait_e_q && mem_return |=> store_step_three)
		else $error("return did not reach step three");
	chk_acc_write: assert property (store_step_three && !inh |=> mem_write_req && mb_from_ar
		&& mem_addr_reg == 18'(instr_reg[9:12])) else $error("bad accumulator write");
	chk_acc_inhibit: assert property (store_step_three && inh |=> store_final_pulse
		&& !mem_write_req) else $error("inhibited store not skipped");
	chk_second_acc: assert property (s_ac_ret ##0 sec |=> ##1 (mb_from_mq && mem_write_req
		&& mem_addr_reg == 18'(instr_reg[9:12]) + 18'h1)) else $error("bad second write");
	chk_single_acc: assert property (s_ac_ret ##0 !sec |=> ##1 store_final_pulse)
		else $error("final step missing");
	chk_return_guard: assert property (mb_from_mq |=> !store_final_pulse [*2])
		else $error("stale return ended chain");
	chk_final_exit: assert property (store_final_pulse |-> (new_instr_cycle || key_cycle
		|| halted) && !(new_instr_cycle && key_cycle)) else $error("bad final exit");
	chk_protect_jump: assert property (protect_violation |=> protect_fault_channel
		&& store_final_pulse) else $error("protection fault not handled");
endmodule : irs_store_ctrl_assertions

// [irs_mem_model.sv]
`timescale 1ns/100ps
module irs_mem_model (
	input wire logic	core_clk,
	input wire logic	arst_n,
	input wire logic	mem_write_req,
	input wire logic	mem_restart_req,
	input wire logic [3:0]	lat,
	output logic	mem_return
);
	logic [3:0]	cnt_q;
	// Latency under two would fall into the design's stale-return window
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			cnt_q <= 4'h0;
		else if (mem_write_req || mem_restart_req)
			cnt_q <= lat;
		else if (cnt_q != 4'h0)
			cnt_q <= cnt_q - 4'h1;
	end
	assign mem_return = (cnt_q == 4'h1);
endmodule : irs_mem_model

// [tb_instr_register_store_control.sv]
`timescale 1ns/100ps
module tb_instr_register_store_control;
	logic	core_clk = 1'b0;
	logic	arst_n = 1'b0;
	logic	hsel = 1'b0, hwrite = 1'b0, hready = 1'b1;
	logic [31:0]	haddr = 32'h0, hwdata = 32'h0, rd;
	logic [1:0]	htrans = 2'h0;
	logic [2:0]	hsize = 3'h2;
	logic [0:17]	mem_buffer_reg = 18'h0;
	logic [8:0]	pl = 9'h0;
	logic [10:0]	lv = 11'h0;
	logic [3:0]	lat = 4'h2;
	wire	exec_final_pulse = pl[0], exec_pulse_three = pl[1], protect_violation = pl[2];
	wire	main_seq_clear = pl[3], instr_cycle_load_pulse = pl[4], addr_cycle_load_pulse = pl[5];
	wire	indirect_clear_pulse = pl[6], char_first_part_done = pl[7], io_start_pulse = pl[8];
	wire	fetch_pause_level = lv[10], store_to_e_write = lv[9], store_to_e_restart = lv[8];
	wire	no_acc_instr = lv[7], mem_mode_instr = lv[6], test_no_result = lv[5];
	wire	cmp_zero_instr = lv[4], block_move_done = lv[3], dbl_shift = lv[2];
	wire	float_low_half = lv[1], fixed_double = lv[0];
	wire	mem_return, hreadyout, hresp, mb_setup_pulse, mem_write_req, mem_restart_req;
	wire	store_step_three, mb_from_ar, mb_from_mq, store_final_pulse, new_instr_cycle;
	wire	key_cycle, halted, protect_fault_channel, indirect_repeat, fc_unused, float_scale;
	wire	float_round, move_group, no_acc_codes, no_index;
	wire [31:0]	hrdata;
	wire [17:0]	mem_addr_reg;
	wire [0:17]	instr_reg;
	wire [0:6]	io_device_sel;
	wire [0:3]	index_sel;
	wire [7:0]	class_lvl, io_op, shift_op, misc_op;
	wire [4:0]	char_op;
	wire [3:0]	float_op, float_mode;
	int	num_errors = 0, total_checks = 0;

	always #2.5 core_clk = ~core_clk;

	irs_store_ctrl irs_store_ctrl_inst (.*);
	irs_mem_model irs_mem_model_inst (.*);

	task end_sim;
		$display("Checks %0d, errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim

	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	task bail(input int n);
		if (n >= 50) begin
			num_errors++;
			end_sim();
		end
	endtask : bail

	task pulse(input int i);
		@(posedge core_clk);
		pl <= 9'h1 << i;
		@(posedge core_clk);
		pl <= 9'h0;
	endtask : pulse

	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		n = 0;
		do begin @(posedge core_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
		bail(n);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		n = 0;
		do begin @(posedge core_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
		bail(n);
		rd = hrdata;
	endtask : ahb

	function automatic logic [0:17] mk(input logic [8:0] c, input logic [3:0] ac, input logic ind,
		input logic [3:0] x);
		mk = {c, ac, ind, x};
	endfunction : mk

	task set_ir(input logic [0:17] v);
		@(posedge core_clk);
		mem_buffer_reg <= v;
		pulse(4);
		pulse(5);
		@(posedge core_clk);
		#1;
	endtask : set_ir

	task chain(input logic [10:0] l, input logic [3:0] lt, input int exw, input logic [17:0] exma,
		input logic [2:0] ex);
		int n;
		int w;
		logic [17:0] ma;
		@(posedge core_clk);
		lv <= l;
		lat <= lt;
		pulse(0);
		n = 0;
		w = 0;
		ma = 18'h0;
		while (n < 50) begin
			#1;
			if (mem_write_req === 1'b1) w++;
			if (mb_from_mq === 1'b1) ma = mem_addr_reg;
			if (store_final_pulse === 1'b1) break;
			n++;
			@(posedge core_clk);
		end
		bail(n);
		chk(w, exw);
		chk(ma, exma);
		chk({new_instr_cycle, key_cycle, halted}, ex);
		@(posedge core_clk);
		lv <= 11'h0;
	endtask : chain

	task reset_regs;
		chk(instr_reg, 18'h0);
		chk({hreadyout, hresp}, 2'h2);
		ahb(1'b1, 8'h10, 32'h1);
		ahb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0);
		ahb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h0);
	endtask : reset_regs

	task ir_ops;
		logic [0:17] v;
		v = mk(9'h053, 4'h8, 1'b1, 4'ha);
		set_ir(v);
		chk(instr_reg, v);
		chk({index_sel, indirect_repeat, no_index}, {4'ha, 2'h2});
		ahb(1'b0, 8'h08, 32'h0);
		chk(rd, {14'h0, v});
		pulse(6);
		#1;
		chk(instr_reg, {v[0:13], 4'h0});
		pulse(8);
		#1;
		chk(instr_reg[12], 1'b1);
		pulse(7);
		#1;
		chk(instr_reg, {v[0:11], 1'b1, 5'h0});
		pulse(3);
		#1;
		chk(instr_reg, 18'h0);
	endtask : ir_ops

	task decode;
		logic [8:0] cd [9] = '{9'h080, 9'h088, 9'h090, 9'h0ac, 9'h0af, 9'h0ab, 9'h040, 9'h059, 9'h05a};
		logic [3:0] ex [9] = '{4'h8, 4'h8, 4'h0, 4'h4, 4'h4, 4'h0, 4'h2, 4'h2, 4'h1};
		for (int i = 0; i < 8; i++) begin
			set_ir(mk({i[2:0], 6'h00}, {1'b1, i[2:0]}, 1'b0, 4'h0));
			chk(class_lvl, 8'h1 << i);
			// Device select lines follow bits 3-9 in every class; only the op decode is gated
			chk({io_op, io_device_sel}, (i == 7) ? 15'h4001 : 15'h0001);
		end
		for (int k = 0; k < 9; k++) begin
			set_ir(mk(cd[k], 4'h1, 1'b0, 4'h1));
			chk({move_group, no_acc_codes, fc_unused, float_scale}, ex[k]);
		end
		set_ir(mk(9'h0a3, 4'h1, 1'b0, 4'h0));
		chk(shift_op, 8'h08);
		set_ir(mk(9'h077, 4'h1, 1'b0, 4'h0));
		chk({float_op, float_mode, float_round}, 9'h091);
		set_ir(mk(9'h05d, 4'h1, 1'b0, 4'h0));
		chk(char_op, 5'h04);
		set_ir(mk(9'h0ae, 4'h1, 1'b0, 4'h0));
		chk(misc_op, 8'h40);
	endtask : decode

	task store_chains;
		logic [10:0] inh [4] = '{11'h080, 11'h040, 11'h020, 11'h008};
		ahb(1'b1, 8'h00, 32'h1);
		set_ir(mk(9'h080, 4'h5, 1'b0, 4'h0));
		chain(11'h204, 4'h2, 3, 18'h6, 3'h4);
		ahb(1'b0, 8'h0c, 32'h0);
		chk(rd, 32'h6);
		chain(11'h100, 4'h6, 1, 18'h0, 3'h4);
		chain(11'h402, 4'h3, 2, 18'h6, 3'h4);
		chain(11'h001, 4'h2, 2, 18'h6, 3'h4);
		chain(11'h010, 4'h2, 1, 18'h0, 3'h4);
		for (int k = 0; k < 4; k++)
			chain(inh[k], 4'h2, 0, 18'h0, 3'h4);
		set_ir(mk(9'h080, 4'h0, 1'b0, 4'h0));
		chain(11'h010, 4'h2, 0, 18'h0, 3'h4);
		set_ir(mk(9'h0ac, 4'h5, 1'b0, 4'h0));
		chain(11'h000, 4'h2, 0, 18'h0, 3'h4);
	endtask : store_chains

	task exits;
		ahb(1'b1, 8'h00, 32'h3);
		ahb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h3);
		chain(11'h080, 4'h2, 0, 18'h0, 3'h2);
		ahb(1'b1, 8'h00, 32'h0);
		chain(11'h080, 4'h2, 0, 18'h0, 3'h1);
		ahb(1'b0, 8'h04, 32'h0);
		chk(rd[7], 1'b1);
		pulse(3);
		pulse(2);
		#1;
		chk({protect_fault_channel, store_final_pulse}, 2'h3);
		set_ir(mk(9'h059, 4'h1, 1'b0, 4'h0));
		pulse(1);
		#1;
		chk(store_final_pulse, 1'b1);
	endtask : exits

	initial begin
		repeat (20) @(posedge core_clk);
		arst_n <= 1'b1;
		reset_regs();
		ir_ops();
		decode();
		store_chains();
		exits();
		end_sim();
	end
endmodule : tb_instr_register_store_control

bind irs_store_ctrl irs_store_ctrl_assertions irs_store_ctrl_assertions_inst (.*);
